// [nfc_pkg.sv]
// nfc_pkg: register map, field positions, reset values and carriers
// assumes a 32-bit classic wishbone slave, byte addresses, one word each
package nfc_pkg;
    // -------------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [11:0] NFC_OFS_CHSEL = 12'h1C0;
    localparam logic [11:0] NFC_OFS_STATUS = 12'h1EC;
    localparam logic [11:0] NFC_OFS_MASK = 12'h1F0;
    localparam logic [11:0] NFC_OFS_STROBE = 12'h1F4;
    localparam logic [11:0] NFC_OFS_SRST = 12'h1F8;
    localparam logic [11:0] NFC_OFS_STROBE_REQ = 12'h1FC;
    // -------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------
    localparam int NFC_BIT_CHSEL = 7;
    localparam int NFC_BIT_RDY = 0;
    localparam int NFC_BIT_MRDY = 0;
    localparam int NFC_BIT_INTEN = 7;
    localparam int NFC_BIT_SRST = 0;
    localparam int NFC_BIT_STB_RD = 0;
    localparam int NFC_BIT_STB_WR = 1;
    localparam logic NFC_RST_CHSEL = 1'b0;
    localparam logic NFC_RST_FLAG = 1'b0;
    localparam logic [3:0] NFC_RST_SPW = 4'h0;
    localparam int NFC_CHANNELS = 2;
    // -------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic inten;
        logic mrdy;
    } nfc_mask_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } nfc_wb_req_type;

    typedef enum logic [1:0] {
        NFC_STB_IDLE = 2'b00,
        NFC_STB_LOW = 2'b01,
        NFC_STB_DONE = 2'b10
    } nfc_stb_state_type;
endpackage

// [nfc_ctrl.sv]
// nfc_ctrl: flash ready interrupt, strobe width, soft reset, channel select
// assumes a classic wishbone master on clk_i and an async ready/busy pin
//
// Behaviour
// [R1] ready flag sets on ready/busy rising edge when mask bit is one
// [R2] writing one clears ready flag, zero leaves it; bits 7:1 reserved
// [R3] interrupt high when enable, mask and ready flag are all one
// [R4] mask bit zero blocks setting the ready flag
// [R5] strobes stay low for strobe width field plus one clocks
// [R6] soft reset bit resets controller state except channel select; resets only the selected channel's registers and the strobe generator
// [R7] soft reset bit clears itself; writing zero does nothing
// [R8] software waits about ten clocks after soft reset before access
// [R9] channel select bit 7 routes shared addresses to channel 0 or 1
// [R10] ready/busy pin synchronised before edge detect, one event each
// [R11] reserved bits read zero and ignore writes
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
module nfc_ctrl
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic flash_ready_busy_in_i,
    output logic flash_read_strobe_n_o,
    output logic flash_write_strobe_n_o,
    output logic flash_interrupt_o
);
    import nfc_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    nfc_wb_req_type req;
    logic chsel;
    logic [NFC_CHANNELS-1:0] rdy;
    nfc_mask_type mask [NFC_CHANNELS];
    logic [3:0] strobe_width_field [NFC_CHANNELS];
    logic [NFC_CHANNELS-1:0] srst;
    logic sync1;
    logic sync2;
    logic sync3;
    logic rise;
    logic wr_hit;
    logic wr_lane0;
    nfc_stb_state_type stb_state;
    nfc_stb_state_type next_stb_state;
    logic [3:0] stb_cnt;
    logic stb_is_wr;
    logic [31:0] next_dat;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                   adr: adr_i, dat: dat_i};
    assign wr_hit = req.cyc && req.stb && req.we && !ack_o;
    assign wr_lane0 = wr_hit && req.sel[0];

    // -------------------------------------------------------------------
    // bus answer: ack one cycle after request, dropped next cycle
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= req.cyc && req.stb && !ack_o;
        end
    end

    always_comb
    begin
        next_dat = 32'h0000_0000; // [R11]
        if (hit(req.adr, NFC_OFS_CHSEL))
        begin
            next_dat[NFC_BIT_CHSEL] = chsel;
        end
        else if (hit(req.adr, NFC_OFS_STATUS))
        begin
            next_dat[NFC_BIT_RDY] = rdy[chsel]; // [R9]
        end
        else if (hit(req.adr, NFC_OFS_MASK))
        begin
            next_dat[NFC_BIT_INTEN] = mask[chsel].inten;
            next_dat[NFC_BIT_MRDY] = mask[chsel].mrdy;
        end
        else if (hit(req.adr, NFC_OFS_STROBE))
        begin
            next_dat[3:0] = strobe_width_field[chsel];
        end
        else if (hit(req.adr, NFC_OFS_SRST))
        begin
            next_dat[NFC_BIT_SRST] = srst[chsel];
        end
        else if (hit(req.adr, NFC_OFS_STROBE_REQ))
        begin
            next_dat[NFC_BIT_STB_RD] = (stb_state != NFC_STB_IDLE);
            next_dat[NFC_BIT_STB_WR] = (stb_state != NFC_STB_IDLE) &&
                                       stb_is_wr;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            dat_o <= (req.cyc && req.stb && !req.we && !ack_o) ?
                next_dat : 32'h0;
        end
    end

    // -------------------------------------------------------------------
    // channel select, untouched by soft reset
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chsel <= NFC_RST_CHSEL;
        end
        else if (wr_lane0 && hit(req.adr, NFC_OFS_CHSEL))
        begin
            chsel <= req.dat[NFC_BIT_CHSEL]; // [R9] [R6]
        end
    end

    // -------------------------------------------------------------------
    // ready/busy synchroniser and edge detect
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // idle level of the pulled-up pin, no false edge after reset
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end
        else
        begin
            sync1 <= flash_ready_busy_in_i; // [R10]
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign rise = sync2 && !sync3; // [R10]

    // -------------------------------------------------------------------
    // per-channel registers
    // -------------------------------------------------------------------
    for (genvar c = 0; c < NFC_CHANNELS; c++)
    begin : g_ch
        logic sel_me;
        logic clr;
        assign sel_me = wr_lane0 && (chsel == 1'(c));
        assign clr = sel_me && hit(req.adr, NFC_OFS_STATUS) &&
                     req.dat[NFC_BIT_RDY];

        // soft reset pulse lasts one cycle, then clears itself
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                srst[c] <= 1'b0;
            end
            else
            begin
                srst[c] <= sel_me && hit(req.adr, NFC_OFS_SRST) &&
                           req.dat[NFC_BIT_SRST] && !srst[c]; // [R7]
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i || srst[c]) // [R6]
            begin
                rdy[c] <= NFC_RST_FLAG;
            end
            else if (rise && mask[c].mrdy) // [R1] [R4]
            begin
                rdy[c] <= 1'b1;
            end
            else if (clr) // [R2]
            begin
                rdy[c] <= 1'b0;
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i || srst[c]) // [R6]
            begin
                mask[c] <= '{inten: 1'b0, mrdy: 1'b0};
                strobe_width_field[c] <= NFC_RST_SPW;
            end
            else if (sel_me && hit(req.adr, NFC_OFS_MASK))
            begin
                mask[c].inten <= req.dat[NFC_BIT_INTEN];
                mask[c].mrdy <= req.dat[NFC_BIT_MRDY]; // [R4]
            end
            else if (sel_me && hit(req.adr, NFC_OFS_STROBE))
            begin
                strobe_width_field[c] <= req.dat[3:0]; // [R11]
            end
        end
    end

    // -------------------------------------------------------------------
    // interrupt
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flash_interrupt_o <= 1'b0;
        end
        else
        begin
            flash_interrupt_o <= (mask[0].inten && mask[0].mrdy && rdy[0]) ||
                (mask[1].inten && mask[1].mrdy && rdy[1]); // [R3]
        end
    end

    // -------------------------------------------------------------------
    // strobe generator: software request, low for width plus one clocks
    // -------------------------------------------------------------------
    always_comb
    begin
        next_stb_state = stb_state;
        case (stb_state)
            NFC_STB_IDLE:
            begin
                if (wr_lane0 && hit(req.adr, NFC_OFS_STROBE_REQ) &&
                    (req.dat[NFC_BIT_STB_RD] || req.dat[NFC_BIT_STB_WR]))
                begin
                    next_stb_state = NFC_STB_LOW;
                end
            end
            NFC_STB_LOW:
            begin
                if (stb_cnt == 4'h0)
                begin
                    next_stb_state = NFC_STB_DONE;
                end
            end
            NFC_STB_DONE:
            begin
                next_stb_state = NFC_STB_IDLE;
            end
            default:
            begin
                next_stb_state = NFC_STB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || srst[chsel]) // [R6]
        begin
            stb_state <= NFC_STB_IDLE;
            stb_cnt <= 4'h0;
            stb_is_wr <= 1'b0;
            flash_read_strobe_n_o <= 1'b1;
            flash_write_strobe_n_o <= 1'b1;
        end
        else
        begin
            stb_state <= next_stb_state;
            if (stb_state == NFC_STB_IDLE &&
                next_stb_state == NFC_STB_LOW)
            begin
                stb_cnt <= strobe_width_field[chsel]; // [R5]
                stb_is_wr <= req.dat[NFC_BIT_STB_WR];
                flash_read_strobe_n_o <= req.dat[NFC_BIT_STB_WR];
                flash_write_strobe_n_o <= !req.dat[NFC_BIT_STB_WR];
            end
            else if (stb_state == NFC_STB_LOW)
            begin
                stb_cnt <= stb_cnt - 4'h1;
                if (stb_cnt == 4'h0)
                begin
                    flash_read_strobe_n_o <= 1'b1; // [R5]
                    flash_write_strobe_n_o <= 1'b1;
                end
            end
        end
    end
endmodule

// [nfc_ctrl_checker.sv]
// nfc_ctrl_checker: port assertions for nfc_ctrl
// assumes binding onto nfc_ctrl, one clock, sync reset
`timescale 1ns/1ns
module nfc_ctrl_checker
import nfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic flash_ready_busy_in_i,
    input wire logic flash_read_strobe_n_o,
    input wire logic flash_write_strobe_n_o,
    input wire logic flash_interrupt_o
);
    logic [4:0] low_cnt;
    logic both_n;
    assign both_n = flash_read_strobe_n_o && flash_write_strobe_n_o;
    always_ff @(posedge clk_i)
    begin
        low_cnt <= both_n ? 5'h00 : low_cnt + 5'h01;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_strobe_fall;
        $fell(flash_read_strobe_n_o) || $fell(flash_write_strobe_n_o);
    endsequence
    a_ack_answer: assert property (s_take |=> ack_o)
        else $error("no ack after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_idle_release: assert property ($fell(rst_i) |->
        !flash_interrupt_o && both_n)
        else $error("outputs busy after reset");
    a_strobe_excl: assert property (!flash_read_strobe_n_o |->
        flash_write_strobe_n_o)
        else $error("both strobes low");
    a_strobe_cause: assert property (s_strobe_fall |->
        $past(cyc_i && stb_i && we_i && !ack_o &&
        adr_i == NFC_OFS_STROBE_REQ))
        else $error("strobe without request");
    a_strobe_width: assert property (low_cnt <= 5'h10)
        else $error("strobe low too long");
    a_quiet_bus: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_status_rsvd: assert property (ack_o && !we_i &&
        adr_i == NFC_OFS_STATUS |-> dat_o[31:1] == 31'h0)
        else $error("status reserved bits set");
    a_irq_cause: assert property ($rose(flash_interrupt_o) |->
        $past(ack_o) || ($past(flash_ready_busy_in_i, 4) &&
        !$past(flash_ready_busy_in_i, 5)))
        else $error("interrupt without cause");
endmodule
bind nfc_ctrl nfc_ctrl_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .sel_i, .adr_i, .dat_i, .dat_o, .ack_o, .flash_ready_busy_in_i,
    .flash_read_strobe_n_o, .flash_write_strobe_n_o, .flash_interrupt_o);

// [nfc_flash_model.sv]
// nfc_flash_model: flash chip, busy after each write strobe
// assumes active-low strobes on clk_i; ready line has a pull-up
`timescale 1ns/1ns
module nfc_flash_model
#(
    parameter int BUSY_CYC = 6
)
(
    input wire logic clk_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    output logic ready_busy_o,
    output logic [4:0] low_width_o,
    output logic was_write_o
);
    logic [4:0] cnt = 5'h00;
    int busy = 0;
    assign ready_busy_o = (busy == 0);
    always @(posedge clk_i)
    begin
        if (!read_strobe_n_i || !write_strobe_n_i)
        begin
            cnt <= cnt + 5'h01;
            low_width_o <= 5'h00;
            was_write_o <= !write_strobe_n_i;
        end
        else if (cnt != 5'h00)
        begin
            low_width_o <= cnt;
            cnt <= 5'h00;
        end
        if (!write_strobe_n_i)
            busy <= BUSY_CYC;
        else if (busy != 0)
            busy <= busy - 1;
    end
endmodule

// [tb_nand_flash_irq_strobe_ctrl.sv]
// tb_nand_flash_irq_strobe_ctrl: self-checking bench for nfc_ctrl
// assumes nfc_pkg, nfc_flash_model and the bound checker
`timescale 1ns/1ns
module tb_nand_flash_irq_strobe_ctrl;
    import nfc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    nfc_wb_req_type req = '0;
    logic [31:0] rdat, v;
    logic ack, rb, rd_n, wr_n, irq;
    logic [4:0] low_w;
    logic was_wr;
    int n_mismatch = 0;
    int check_count = 0;
    nfc_ctrl dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(req.cyc),
        .stb_i(req.stb), .we_i(req.we), .sel_i(req.sel), .adr_i(req.adr),
        .dat_i(req.dat), .dat_o(rdat), .ack_o(ack),
        .flash_ready_busy_in_i(rb), .flash_read_strobe_n_o(rd_n),
        .flash_write_strobe_n_o(wr_n), .flash_interrupt_o(irq));
    nfc_flash_model flash_u (.clk_i(clk), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .ready_busy_o(rb), .low_width_o(low_w),
        .was_write_o(was_wr));
    initial forever #4 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        req <= '{1'b1, 1'b1, w, 4'h1, a, d};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        v = rdat;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic results;
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic t_regs;
        logic [11:0] ofs[4] = '{NFC_OFS_CHSEL, NFC_OFS_MASK,
            NFC_OFS_STROBE, 12'h100};
        logic [31:0] exp[4] = '{32'h80, 32'h81, 32'h0F, 32'h00};
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b0, ofs[i], 32'h0);
            check(v, 32'h0);
            xfer(1'b1, ofs[i], 32'hFF);
            xfer(1'b0, ofs[i], 32'h0);
            check(v, exp[i]);
            xfer(1'b1, ofs[i], 32'h0);
        end
    endtask
    task automatic t_width;
        logic [3:0] w[3] = '{4'h0, 4'h2, 4'hF};
        logic [31:0] e;
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, NFC_OFS_STROBE, {28'h0, w[i]});
            for (int s = 1; s <= 2; s++)
            begin
                e = (s == 2) ? 32'h3 : 32'h1;
                xfer(1'b1, NFC_OFS_STROBE_REQ, s);
                xfer(1'b0, NFC_OFS_STROBE_REQ, 32'h0);
                check(v, (w[i] == 4'h0) ? 32'h0 : e);
                repeat (30) @(posedge clk);
                check(low_w, w[i] + 5'h01);
                check(was_wr, s == 2);
            end
        end
        xfer(1'b0, NFC_OFS_STATUS, 32'h0);
        check(v, 32'h0);
    endtask
    task automatic t_ready;
        xfer(1'b1, NFC_OFS_MASK, 32'h01);
        xfer(1'b1, NFC_OFS_STROBE_REQ, 32'h2);
        repeat (30) @(posedge clk);
        xfer(1'b0, NFC_OFS_STATUS, 32'h0);
        check(v, 32'h1);
        check(irq, 1'b0);
        xfer(1'b1, NFC_OFS_MASK, 32'h81);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        xfer(1'b1, NFC_OFS_STATUS, 32'h0);
        xfer(1'b0, NFC_OFS_STATUS, 32'h0);
        check(v, 32'h1);
        xfer(1'b1, NFC_OFS_STATUS, 32'h1);
        repeat (10) @(posedge clk);
        check(irq, 1'b0);
        xfer(1'b0, NFC_OFS_STATUS, 32'h0);
        check(v, 32'h0);
    endtask
    task automatic t_srst;
        xfer(1'b1, NFC_OFS_CHSEL, 32'h80);
        xfer(1'b0, NFC_OFS_MASK, 32'h0);
        check(v, 32'h0);
        xfer(1'b1, NFC_OFS_MASK, 32'h81);
        xfer(1'b1, NFC_OFS_STROBE, 32'h5);
        xfer(1'b1, NFC_OFS_SRST, 32'h1);
        repeat (10) @(posedge clk);
        xfer(1'b0, NFC_OFS_SRST, 32'h0);
        check(v, 32'h0);
        xfer(1'b0, NFC_OFS_MASK, 32'h0);
        check(v, 32'h0);
        xfer(1'b0, NFC_OFS_STROBE, 32'h0);
        check(v, 32'h0);
        xfer(1'b0, NFC_OFS_CHSEL, 32'h0);
        check(v, 32'h80);
        xfer(1'b1, NFC_OFS_MASK, 32'h01);
        xfer(1'b1, NFC_OFS_SRST, 32'h0);
        xfer(1'b0, NFC_OFS_MASK, 32'h0);
        check(v, 32'h01);
        xfer(1'b1, NFC_OFS_CHSEL, 32'h0);
        xfer(1'b0, NFC_OFS_MASK, 32'h0);
        check(v, 32'h81);
    endtask
    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_width();
        t_ready();
        t_srst();
        results();
    end
endmodule
